// [verilog/eedu_top.sv]
// event detection, sequencing, timing, masking and ram monitor of the emulator
`timescale 1ns/1ps
`default_nettype none
`include "eedu_params.svh"

module eedu_top #(
	parameter int MON_AW = 10,
	parameter logic [31:0] MON_BASE = 32'h0000_0000,
	parameter int FRZ_W = 8
) (
	input  wire logic                                         ref_clk,
	input  wire logic                                         reset_n,
	input  wire eedu_pkg::eedu_cpu_bus_type                   cpu_bus,
	input  wire logic                                         in_break,
	input  wire logic                                         cfg_load,
	input  wire eedu_pkg::eedu_pre_cfg_type  [1:0]            pre_cfg_in,
	input  wire eedu_pkg::eedu_post_cfg_type [7:0]            post_cfg_in,
	input  wire eedu_pkg::eedu_acc_cfg_type  [5:0]            acc_cfg_in,
	input  wire logic                                         link_en,
	input  wire logic [3:0]                                   link_first_sel,
	input  wire logic [3:0]                                   link_second_sel,
	input  wire logic [`EEDU_BRK_W-1:0]                       brk_sel,
	input  wire logic [`EEDU_EV_W-1:0]                        trc_sel,
	input  wire logic [3:0]                                   tm_start_sel,
	input  wire logic [3:0]                                   tm_stop_sel,
	input  wire logic                                         ext_reset_in,
	input  wire logic                                         int_reset_in,
	input  wire logic                                         nmi_in,
	input  wire logic                                         bus_hold_request_in,
	input  wire logic                                         ext_wait_in,
	input  wire logic [4:0]                                   src_mask,
	input  wire logic                                         tif_low,
	input  wire logic                                         prog_running,
	input  wire logic [MON_AW-1:0]                            mon_rd_addr,
	input  wire logic                                         mon_flag_clr,
	input  wire logic [FRZ_W-1:0]                             freeze_sel,
	output logic                                              cfg_error,
	output logic [`EEDU_EV_W-1:0]                             event_hit,
	output logic                                              break_req,
	output logic                                              break_at_mem,
	output logic                                              trace_qual,
	output logic                                              tm_running,
	output logic [`EEDU_TM_W-1:0]                             tm_max,
	output logic [`EEDU_TM_W-1:0]                             tm_min,
	output logic [`EEDU_TM_W-1:0]                             tm_avg,
	output logic [`EEDU_CNT_W-1:0]                            tm_pass_count,
	output logic                                              cpu_reset,
	output logic                                              cpu_nmi,
	output logic                                              cpu_hold_req,
	output logic                                              cpu_wait,
	output logic                                              lv_reset_active,
	output logic [31:0]                                       mon_rd_data,
	output logic                                              mon_was_read,
	output logic                                              mon_was_written,
	output logic                                              wdt_stop,
	output logic [FRZ_W-1:0]                                  periph_freeze
);
	localparam int SUM_W = `EEDU_TM_W + `EEDU_CNT_W;
	localparam int MON_N = 1 << MON_AW;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	// inclusive window or single address compare
	function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi, input logic rng);
		addr_hit = rng ? (a >= lo && a <= hi) : (a == lo);
	endfunction

	// comparator points consumed: one per event, one more per range
	function automatic logic [4:0] points_used(input logic [7:0] en, input logic [7:0] rng);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 8; i++) begin
			n = n + {4'h0, en[i]} + {4'h0, en[i] & rng[i]};
		end
		points_used = n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// configuration load with allocation check
	eedu_pkg::eedu_pre_cfg_type  [1:0] pre_cfg;
	eedu_pkg::eedu_post_cfg_type [7:0] post_cfg;
	eedu_pkg::eedu_acc_cfg_type  [5:0] acc_cfg;
	logic [7:0] post_en_in, post_rng_in, acc_en_in, acc_rng_in;
	wire logic [4:0] post_need;
	wire logic [4:0] acc_need;
	wire logic       alloc_bad;

	// gather enable and range bits of requested events
	always_comb begin
		post_en_in = 8'h00;
		post_rng_in = 8'h00;
		acc_en_in = 8'h00;
		acc_rng_in = 8'h00;
		for (int i = 0; i < `EEDU_POST_PTS; i++) begin
			post_en_in[i] = post_cfg_in[i].en;
			post_rng_in[i] = post_cfg_in[i].range;
		end
		for (int i = 0; i < `EEDU_ACC_PTS; i++) begin
			acc_en_in[i] = acc_cfg_in[i].en;
			acc_rng_in[i] = acc_cfg_in[i].range;
		end
	end
	assign post_need = points_used(post_en_in, post_rng_in);
	assign acc_need = points_used(acc_en_in, acc_rng_in);
	assign alloc_bad = (post_need > 5'(`EEDU_POST_PTS)) || (acc_need > 5'(`EEDU_ACC_PTS));

	// a rejected load keeps the previous event set active
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cfg <= '0;
			post_cfg <= '0;
			acc_cfg <= '0;
			cfg_error <= 1'b0;
		end else if (cfg_load) begin
			cfg_error <= alloc_bad;
			if (!alloc_bad) begin
				pre_cfg <= pre_cfg_in;
				post_cfg <= post_cfg_in;
				acc_cfg <= acc_cfg_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// comparators
	logic [1:0] pre_raw;
	logic [7:0] post_raw;
	logic [5:0] acc_raw;
	genvar g;
	generate
		for (g = 0; g < `EEDU_PRE_PTS; g++) begin : g_pre
			assign pre_raw[g] = pre_cfg[g].en & cpu_bus.fetch_v
				& (cpu_bus.fetch_addr == pre_cfg[g].addr);
		end
		for (g = 0; g < `EEDU_POST_PTS; g++) begin : g_post
			assign post_raw[g] = post_cfg[g].en & cpu_bus.retire_v
				& addr_hit(cpu_bus.retire_addr, post_cfg[g].lo, post_cfg[g].hi,
				post_cfg[g].range);
		end
		for (g = 0; g < `EEDU_ACC_PTS; g++) begin : g_acc
			assign acc_raw[g] = acc_cfg[g].en & cpu_bus.acc_v
				& addr_hit(cpu_bus.acc_addr, acc_cfg[g].lo, acc_cfg[g].hi, acc_cfg[g].range)
				& (((cpu_bus.acc_data ^ acc_cfg[g].data) & acc_cfg[g].data_mask) == 32'h0)
				& (cpu_bus.acc_size == acc_cfg[g].size)
				& (cpu_bus.acc_write ? acc_cfg[g].dir[1] : acc_cfg[g].dir[0]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// event link: first selected hit arms, second selected hit fires
	logic             link_armed;
	wire logic [13:0] base_raw = {acc_raw, post_raw};
	wire logic        link_first = (link_first_sel < 4'he) && base_raw[link_first_sel];
	wire logic        link_second = (link_second_sel < 4'he) && base_raw[link_second_sel];
	wire logic        link_raw = link_en & link_armed & link_second;
	wire logic [`EEDU_EV_W-1:0] ev_raw = {link_raw, base_raw};

	// arming persists until the second event or link disable
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			link_armed <= 1'b0;
		end else if (!link_en || link_raw) begin
			link_armed <= 1'b0;
		end else if (link_first) begin
			link_armed <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one-cycle hit pulses and routing to break and trace

	wire logic [`EEDU_BRK_W-1:0] brk_vec = {pre_raw, ev_raw} & brk_sel;
	wire logic acc_brk = |brk_vec[13:8];
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			event_hit <= '0;
			break_req <= 1'b0;
			break_at_mem <= 1'b0;
			trace_qual <= 1'b0;
		end else begin
			event_hit <= ev_raw;
			break_req <= |brk_vec;
			break_at_mem <= acc_brk;
			trace_qual <= |(ev_raw & trc_sel);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// section time measurement
	eedu_pkg::eedu_tm_state_type tm_state;
	logic [`EEDU_TM_W-1:0] tm_cur;
	logic [SUM_W-1:0]      tm_sum, div_quo;
	logic [`EEDU_CNT_W:0]  div_rem;
	logic [5:0]            div_step;
	wire logic tm_start = (tm_start_sel < 4'hf) && event_hit[tm_start_sel];
	wire logic tm_stop = (tm_stop_sel < 4'hf) && event_hit[tm_stop_sel];
	wire logic [`EEDU_TM_W-1:0] tm_end = tm_cur + `EEDU_TM_W'(1);
	wire logic [`EEDU_CNT_W:0] div_shift = {div_rem[`EEDU_CNT_W-1:0], div_quo[SUM_W-1]};
	wire logic div_ge = div_shift >= {1'b0, tm_pass_count};

	// idle -> run on start, run -> divide on stop, divide rebuilds average
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tm_state <= eedu_pkg::EEDU_TM_IDLE;
			tm_cur <= '0;
			tm_max <= '0;
			tm_min <= '1;
			tm_avg <= '0;
			tm_sum <= '0;
			tm_pass_count <= '0;
			tm_running <= 1'b0;
			div_quo <= '0;
			div_rem <= '0;
			div_step <= 6'h00;
		end else begin
			case (tm_state)
				eedu_pkg::EEDU_TM_IDLE: begin
					if (tm_start) begin
						tm_state <= eedu_pkg::EEDU_TM_RUN;
						tm_cur <= '0;
						tm_running <= 1'b1;
					end
				end
				eedu_pkg::EEDU_TM_RUN: begin
					tm_cur <= tm_end;
					if (tm_stop) begin
						tm_state <= eedu_pkg::EEDU_TM_DIV;
						tm_running <= 1'b0;
						tm_max <= (tm_end > tm_max) ? tm_end : tm_max;
						tm_min <= (tm_end < tm_min) ? tm_end : tm_min;
						tm_pass_count <= tm_pass_count + `EEDU_CNT_W'(1);
						tm_sum <= tm_sum + SUM_W'(tm_end);
						div_quo <= tm_sum + SUM_W'(tm_end);
						div_rem <= '0;
						div_step <= 6'(SUM_W);
					end
				end
				eedu_pkg::EEDU_TM_DIV: begin
					div_rem <= div_ge ? div_shift - {1'b0, tm_pass_count} : div_shift;
					div_quo <= {div_quo[SUM_W-2:0], div_ge};
					div_step <= div_step - 6'h01;
					if (div_step == 6'h01) begin
						tm_avg <= `EEDU_TM_W'({div_quo[SUM_W-2:0], div_ge});
						tm_state <= eedu_pkg::EEDU_TM_IDLE;
					end
				end
				default: tm_state <= eedu_pkg::EEDU_TM_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// source masks and low-voltage reset hold
	logic lv_hold;
	wire logic next_cpu_reset = (ext_reset_in & ~src_mask[0])
		| (int_reset_in & ~src_mask[1]) | lv_hold;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lv_hold <= 1'b0;
			cpu_reset <= 1'b0;
			cpu_nmi <= 1'b0;
			cpu_hold_req <= 1'b0;
			cpu_wait <= 1'b0;
			lv_reset_active <= 1'b0;
			wdt_stop <= 1'b0;
			periph_freeze <= '0;
		end else begin
			if (!tif_low) begin
				lv_hold <= 1'b0;
			end else if (prog_running) begin
				lv_hold <= 1'b1;
			end
			cpu_reset <= next_cpu_reset;
			cpu_nmi <= nmi_in & ~src_mask[2];
			cpu_hold_req <= bus_hold_request_in & ~src_mask[3];
			cpu_wait <= ext_wait_in & ~src_mask[4];
			lv_reset_active <= lv_hold;
			wdt_stop <= in_break;
			periph_freeze <= in_break ? freeze_sel : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// real-time ram monitor on its own read port
	logic [31:0] mon_mem [0:MON_N-1];
	logic [MON_N-1:0] rd_flag, wr_flag;
	wire logic in_win = cpu_bus.acc_addr[31:MON_AW+2] == MON_BASE[31:MON_AW+2];
	wire logic [MON_AW-1:0] mon_idx = cpu_bus.acc_addr[MON_AW+1:2];
	wire logic cpu_acc = cpu_bus.acc_v & in_win & ~cpu_bus.acc_by_dma & ~in_break;
	wire logic mon_wr = cpu_acc & cpu_bus.acc_write;
	wire logic mon_rd = cpu_acc & ~cpu_bus.acc_write;

	// copy follows cpu writes only
	always_ff @(posedge ref_clk) begin
		if (mon_wr) begin
			mon_mem[mon_idx] <= cpu_bus.acc_data;
		end
		mon_rd_data <= mon_mem[mon_rd_addr];
	end

	// access flags, a new access beats a clear in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_flag <= '0;
			wr_flag <= '0;
			mon_was_read <= 1'b0;
			mon_was_written <= 1'b0;
		end else begin
			rd_flag <= (mon_flag_clr ? '0 : rd_flag) | (MON_N'(mon_rd) << mon_idx);
			wr_flag <= (mon_flag_clr ? '0 : wr_flag) | (MON_N'(mon_wr) << mon_idx);
			mon_was_read <= rd_flag[mon_rd_addr];
			mon_was_written <= wr_flag[mon_rd_addr];
		end
	end
endmodule
`default_nettype wire

// [common/eedu_params.svh]
// constants for the emulator event detect unit
`ifndef EEDU_PARAMS_SVH
`define EEDU_PARAMS_SVH
`define EEDU_PRE_PTS   2
`define EEDU_POST_PTS  8
`define EEDU_ACC_PTS   6
`define EEDU_EV_W      15
`define EEDU_BRK_W     17
`define EEDU_DIR_READ  2'h1
`define EEDU_DIR_WRITE 2'h2
`define EEDU_LINK_BIT  14
`define EEDU_TM_W      32
`define EEDU_CNT_W     16
`endif

// [common/eedu_pkg.sv]
// types shared by the emulator event detect unit
package eedu_pkg;
	typedef struct packed {
		logic        fetch_v;
		logic [31:0] fetch_addr;
		logic        retire_v;
		logic [31:0] retire_addr;
		logic        acc_v;
		logic        acc_write;
		logic        acc_by_dma;
		logic [1:0]  acc_size;
		logic [31:0] acc_addr;
		logic [31:0] acc_data;
	} eedu_cpu_bus_type;
	typedef struct packed {
		logic        en;
		logic [31:0] addr;
	} eedu_pre_cfg_type;
	typedef struct packed {
		logic        en;
		logic        range;
		logic [31:0] lo;
		logic [31:0] hi;
	} eedu_post_cfg_type;
	typedef struct packed {
		logic        en;
		logic        range;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [31:0] data;
		logic [31:0] data_mask;
		logic [1:0]  size;
		logic [1:0]  dir;
	} eedu_acc_cfg_type;
	typedef enum logic [1:0] {EEDU_TM_IDLE, EEDU_TM_RUN, EEDU_TM_DIV} eedu_tm_state_type;
endpackage

// [verif/eedu_cpu_model.sv]
// behavioural model of the emulated cpu bus
`timescale 1ns/1ps
`default_nettype none
module eedu_cpu_model (
	input  wire logic                  ref_clk,
	output var eedu_pkg::eedu_cpu_bus_type cpu_bus
);
	initial cpu_bus = '0;
	// one bus cycle; released lines then carry the inverse so stale values never match
	task automatic drive(input eedu_pkg::eedu_cpu_bus_type b);
		eedu_pkg::eedu_cpu_bus_type r;
		r = ~b;
		r.fetch_v = 1'h0;
		r.retire_v = 1'h0;
		r.acc_v = 1'h0;
		@(posedge ref_clk);
		cpu_bus <= b;
		@(posedge ref_clk);
		cpu_bus <= r;
	endtask
endmodule
`default_nettype wire

// [verif/eedu_top_properties.sv]
// port assertions of the event detect unit
`timescale 1ns/1ps
`default_nettype none
`include "eedu_params.svh"
module eedu_top_properties #(
	parameter int FRZ_W = 8
) (
	input wire logic                       ref_clk,
	input wire logic                       reset_n,
	input wire eedu_pkg::eedu_cpu_bus_type cpu_bus,
	input wire logic                       in_break,
	input wire logic [FRZ_W-1:0]           freeze_sel,
	input wire logic [`EEDU_BRK_W-1:0]     brk_sel,
	input wire logic [`EEDU_EV_W-1:0]      trc_sel,
	input wire logic                       nmi_in,
	input wire logic [4:0]                 src_mask,
	input wire logic                       tif_low,
	input wire logic                       prog_running,
	input wire logic [`EEDU_EV_W-1:0]      event_hit,
	input wire logic                       break_at_mem,
	input wire logic                       trace_qual,
	input wire logic                       cpu_reset,
	input wire logic                       cpu_nmi,
	input wire logic                       lv_reset_active,
	input wire logic                       wdt_stop,
	input wire logic [FRZ_W-1:0]           periph_freeze
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////
	// supply low while running, and supply back for two samples
	sequence s_low;
		tif_low && prog_running;
	endsequence
	sequence s_back;
		!tif_low [*2];
	endsequence
	property p_lv_set;
		s_low |-> ##2 cpu_reset;
	endproperty
	a_lv_set: assert property (p_lv_set) else $error("no target reset on low supply");
	property p_lv_clr;
		s_back |=> !lv_reset_active;
	endproperty
	a_lv_clr: assert property (p_lv_clr) else $error("low supply reset not released");
	property p_freeze;
		$past(reset_n) |-> wdt_stop == $past(in_break)
			&& periph_freeze == ($past(freeze_sel) & {FRZ_W{$past(in_break)}});
	endproperty
	a_freeze: assert property (p_freeze) else $error("break stop outputs wrong");
	property p_nmi;
		$past(reset_n) |-> cpu_nmi == $past(nmi_in && !src_mask[2]);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi mask wrong");
	property p_trace;
		$past(reset_n) |-> trace_qual == |(event_hit & $past(trc_sel));
	endproperty
	a_trace: assert property (p_trace) else $error("trace qualifier wrong");
	property p_mem_brk;
		|(event_hit[13:8] & $past(brk_sel[13:8])) |-> break_at_mem;
	endproperty
	a_mem_brk: assert property (p_mem_brk) else $error("access break not at mem stage");
	property p_acc_cause;
		|event_hit[13:8] |-> $past(cpu_bus.acc_v);
	endproperty
	a_acc_cause: assert property (p_acc_cause) else $error("access hit without access");
	property p_post_cause;
		|event_hit[7:0] |-> $past(cpu_bus.retire_v);
	endproperty
	a_post_cause: assert property (p_post_cause) else $error("post hit without retire");
endmodule
bind eedu_top eedu_top_properties #(.FRZ_W(FRZ_W)) eedu_top_properties_i (
	.ref_clk, .reset_n, .cpu_bus, .in_break, .freeze_sel, .brk_sel, .trc_sel, .nmi_in,
	.src_mask, .tif_low, .prog_running, .event_hit, .break_at_mem, .trace_qual,
	.cpu_reset, .cpu_nmi, .lv_reset_active, .wdt_stop, .periph_freeze
);
`default_nettype wire

// [verif/eedu_top_test.sv]
// self-checking bench for the event detect unit
`timescale 1ns/1ps
`default_nettype none
`include "eedu_params.svh"
module eedu_top_test;
	logic ref_clk, reset_n, in_break, cfg_load, link_en, ext_reset_in, int_reset_in, nmi_in;
	logic bus_hold_request_in, ext_wait_in, tif_low, prog_running, mon_flag_clr, cfg_error;
	logic break_req, break_at_mem, trace_qual, tm_running, cpu_reset, cpu_nmi, cpu_hold_req;
	logic cpu_wait, lv_reset_active, mon_was_read, mon_was_written, wdt_stop;
	logic [3:0]  link_first_sel, link_second_sel, tm_start_sel, tm_stop_sel;
	logic [16:0] brk_sel;
	logic [14:0] trc_sel, event_hit;
	logic [4:0]  src_mask;
	logic [9:0]  mon_rd_addr;
	logic [7:0]  freeze_sel, periph_freeze;
	logic [31:0] tm_max, tm_min, tm_avg, mon_rd_data;
	logic [15:0] tm_pass_count;
	eedu_pkg::eedu_cpu_bus_type        cpu_bus;
	eedu_pkg::eedu_pre_cfg_type  [1:0] pre_cfg_in;
	eedu_pkg::eedu_post_cfg_type [7:0] post_cfg_in;
	eedu_pkg::eedu_acc_cfg_type  [5:0] acc_cfg_in;
	int error_cnt = 0;
	int compares = 0;
	eedu_top eedu_top_i (.ref_clk, .reset_n, .cpu_bus, .in_break, .cfg_load, .pre_cfg_in,
		.post_cfg_in, .acc_cfg_in, .link_en, .link_first_sel, .link_second_sel, .brk_sel,
		.trc_sel, .tm_start_sel, .tm_stop_sel, .ext_reset_in, .int_reset_in, .nmi_in,
		.bus_hold_request_in, .ext_wait_in, .src_mask, .tif_low, .prog_running, .mon_rd_addr,
		.mon_flag_clr, .freeze_sel, .cfg_error, .event_hit, .break_req, .break_at_mem,
		.trace_qual, .tm_running, .tm_max, .tm_min, .tm_avg, .tm_pass_count, .cpu_reset,
		.cpu_nmi, .cpu_hold_req, .cpu_wait, .lv_reset_active, .mon_rd_data, .mon_was_read,
		.mon_was_written, .wdt_stop, .periph_freeze);
	eedu_cpu_model eedu_cpu_model_i (.ref_clk, .cpu_bus);
	// 20 mhz clock
	initial ref_clk = 1'h0;
	always #25 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic close_out;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// pulse cfg_load and check the allocation verdict
	task automatic load(input logic e);
		@(posedge ref_clk);
		cfg_load <= 1'h1;
		@(posedge ref_clk);
		cfg_load <= 1'h0;
		wt(0);
		chk("cfg_error", e, cfg_error);
	endtask
	// kind 0 fetch, 1 retire, 2 access, 3 dma access; h[15] is the expected break
	task automatic ev(input logic [1:0] k, input logic w, input logic [1:0] s,
			input logic [31:0] a, input logic [31:0] d, input logic [15:0] h);
		eedu_pkg::eedu_cpu_bus_type b;
		b = '0;
		b.fetch_v = (k == 2'h0);
		b.retire_v = (k == 2'h1);
		b.acc_v = k[1];
		b.acc_by_dma = (k == 2'h3);
		b.acc_write = w;
		b.acc_size = s;
		{b.fetch_addr, b.retire_addr, b.acc_addr, b.acc_data} = {a, a, a, d};
		eedu_cpu_model_i.drive(b);
		wt(0);
		chk("event_hit", h[14:0], event_hit);
		chk("brk_trc_mem", {h[15], |h[14:0], h[8]}, {break_req, trace_qual, break_at_mem});
		wt(1);
		chk("hit_end", 15'h0, event_hit);
	endtask
	function automatic eedu_pkg::eedu_acc_cfg_type acfg(input logic r, input logic [31:0] lo,
			input logic [31:0] hi, input logic [31:0] m, input logic [1:0] dir);
		acfg = {1'h1, r, lo, hi, 32'h55, m, 2'h2, dir};
	endfunction
	// hang guard
	initial begin
		#400000;
		error_cnt++;
		close_out();
	end
	////////////////////////////////////////////////////////////
	initial begin
		{cfg_load, in_break, link_en, ext_reset_in, int_reset_in, nmi_in, mon_flag_clr} = '0;
		{bus_hold_request_in, ext_wait_in, tif_low, prog_running, src_mask} = '0;
		{mon_rd_addr, freeze_sel} = '0;
		{link_first_sel, link_second_sel, tm_start_sel, tm_stop_sel} = 16'hffff;
		brk_sel = 17'h08100;
		trc_sel = 15'h7fff;
		{pre_cfg_in, post_cfg_in, acc_cfg_in} = '0;
		pre_cfg_in[0] = {1'h1, 32'h100};
		post_cfg_in[0] = {2'h2, 32'h200, 32'h200};
		post_cfg_in[1] = {2'h3, 32'h300, 32'h30f};
		acc_cfg_in[0] = acfg(1'h1, 32'h40, 32'h7f, 32'hff, 2'h1);
		acc_cfg_in[1] = acfg(1'h0, 32'h80, 32'h80, 32'h0, 2'h2);
		acc_cfg_in[2] = acfg(1'h0, 32'h84, 32'h84, 32'h0, 2'h3);
		reset_n = 1'h0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'h1;
		wt(1);
		chk("tm_min", 32'hffffffff, tm_min);
		load(1'h0);
		ev(2'h0, 1'h0, 2'h2, 32'h100, 32'h0, 16'h8000);
		ev(2'h0, 1'h0, 2'h2, 32'h104, 32'h0, 16'h0000);
		ev(2'h1, 1'h0, 2'h2, 32'h100, 32'h0, 16'h0000);
		ev(2'h1, 1'h0, 2'h2, 32'h200, 32'h0, 16'h0001);
		ev(2'h1, 1'h0, 2'h2, 32'h2ff, 32'h0, 16'h0000);
		ev(2'h1, 1'h0, 2'h2, 32'h300, 32'h0, 16'h0002);
		ev(2'h1, 1'h0, 2'h2, 32'h30f, 32'h0, 16'h0002);
		ev(2'h1, 1'h0, 2'h2, 32'h310, 32'h0, 16'h0000);
		ev(2'h2, 1'h0, 2'h2, 32'h40, 32'h1255, 16'h8100);
		ev(2'h2, 1'h1, 2'h2, 32'h7f, 32'h55, 16'h0000);
		ev(2'h2, 1'h0, 2'h2, 32'h7f, 32'h56, 16'h0000);
		ev(2'h2, 1'h0, 2'h1, 32'h7f, 32'h55, 16'h0000);
		ev(2'h2, 1'h0, 2'h2, 32'h7f, 32'h55, 16'h8100);
		ev(2'h2, 1'h0, 2'h2, 32'h80, 32'h0, 16'h0000);
		ev(2'h2, 1'h1, 2'h2, 32'h80, 32'h0, 16'h0200);
		ev(2'h2, 1'h0, 2'h2, 32'h84, 32'h0, 16'h0400);
		ev(2'h2, 1'h1, 2'h2, 32'h84, 32'h0, 16'h0400);
		// linked event: access match first, then retire match
		@(posedge ref_clk);
		{link_en, link_first_sel, link_second_sel} <= {1'h1, 4'h8, 4'h0};
		ev(2'h1, 1'h0, 2'h2, 32'h200, 32'h0, 16'h0001);
		ev(2'h2, 1'h0, 2'h2, 32'h40, 32'h55, 16'h8100);
		ev(2'h1, 1'h0, 2'h2, 32'h200, 32'h0, 16'h4001);
		ev(2'h1, 1'h0, 2'h2, 32'h200, 32'h0, 16'h0001);
		// section timing from post point 0 to post point 1
		@(posedge ref_clk);
		{link_en, tm_start_sel, tm_stop_sel} <= {1'h0, 4'h0, 4'h1};
		ev(2'h1, 1'h0, 2'h2, 32'h200, 32'h0, 16'h0001);
		chk("tm_running", 1'h1, tm_running);
		ev(2'h1, 1'h0, 2'h2, 32'h0, 32'h0, 16'h0000);
		ev(2'h1, 1'h0, 2'h2, 32'h300, 32'h0, 16'h0002);
		chk("tm_running", 1'h0, tm_running);
		wt(60);
		chk("tm_1", {32'h6, 32'h6, 32'h6, 16'h1}, {tm_max, tm_min, tm_avg, tm_pass_count});
		ev(2'h1, 1'h0, 2'h2, 32'h200, 32'h0, 16'h0001);
		ev(2'h1, 1'h0, 2'h2, 32'h300, 32'h0, 16'h0002);
		wt(60);
		chk("tm_2", {32'h6, 32'h3, 32'h4, 16'h2}, {tm_max, tm_min, tm_avg, tm_pass_count});
		// pool overflow refused, exact fill accepted
		@(posedge ref_clk);
		for (int i = 3; i < 8; i++) post_cfg_in[i] <= {2'h3, 32'h0, 32'h0};
		load(1'h1);
		ev(2'h1, 1'h0, 2'h2, 32'h0, 32'h0, 16'h0000);
		@(posedge ref_clk);
		post_cfg_in[7:6] <= '0;
		post_cfg_in[5].range <= 1'h0;
		load(1'h0);
		ev(2'h1, 1'h0, 2'h2, 32'h0, 32'h0, 16'h0038);
		@(posedge ref_clk);
		acc_cfg_in[5:3] <= {3{acfg(1'h1, 32'h0, 32'h0, 32'h0, 2'h3)}};
		load(1'h1);
		@(posedge ref_clk);
		acc_cfg_in[5:4] <= '0;
		load(1'h0);
		ev(2'h2, 1'h0, 2'h2, 32'h0, 32'h9, 16'h0800);
		// every source mask code
		@(posedge ref_clk);
		{ext_reset_in, int_reset_in, nmi_in, bus_hold_request_in, ext_wait_in} <= 5'h1f;
		for (int m = 0; m < 32; m++) begin
			@(posedge ref_clk);
			src_mask <= m[4:0];
			wt(2);
			chk("masks", {!(m[0] && m[1]), !m[2], !m[3], !m[4]},
				{cpu_reset, cpu_nmi, cpu_hold_req, cpu_wait});
		end
		// low target supply
		@(posedge ref_clk);
		{ext_reset_in, int_reset_in, nmi_in, bus_hold_request_in, ext_wait_in} <= 5'h0;
		tif_low <= 1'h1;
		wt(3);
		chk("lv_idle", 2'h0, {cpu_reset, lv_reset_active});
		prog_running <= 1'h1;
		wt(3);
		chk("lv_low", 2'h3, {cpu_reset, lv_reset_active});
		tif_low <= 1'h0;
		wt(3);
		chk("lv_back", 2'h0, {cpu_reset, lv_reset_active});
		// ram monitor: cpu write kept, dma and break writes ignored
		@(posedge ref_clk);
		mon_rd_addr <= 10'h4;
		ev(2'h2, 1'h1, 2'h2, 32'h10, 32'hcafef00d, 16'h0);
		chk("mon_wr", {32'hcafef00d, 2'h1}, {mon_rd_data, mon_was_read, mon_was_written});
		ev(2'h3, 1'h1, 2'h2, 32'h10, 32'h0, 16'h0);
		chk("mon_dma", 32'hcafef00d, mon_rd_data);
		{in_break, freeze_sel} <= {1'h1, 8'ha5};
		ev(2'h2, 1'h1, 2'h2, 32'h10, 32'h1, 16'h0);
		chk("mon_brk", 32'hcafef00d, mon_rd_data);
		chk("brk_stop", {1'h1, 8'ha5}, {wdt_stop, periph_freeze});
		{in_break, mon_rd_addr} <= {1'h0, 10'h5};
		ev(2'h2, 1'h0, 2'h2, 32'h14, 32'h0, 16'h0);
		chk("mon_rd", 3'h4, {mon_was_read, mon_was_written, cpu_wait});
		mon_flag_clr <= 1'h1;
		wt(1);
		mon_flag_clr <= 1'h0;
		wt(2);
		chk("mon_clr", 2'h0, {mon_was_read, mon_was_written});
		close_out();
	end
endmodule
`default_nettype wire
